// >>> asc_top.sv
// Scan select and pin configuration registers with APB slave
`timescale 1ns/1ps
`default_nettype none
module asc_top
   import asc_pkg::*;
#(
   parameter int NUM_PINS = 24,
   parameter bit HAS_SECOND = 1'b1
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic converter_module_disable,
   input wire logic scan_advance,
   output logic [ASC_IDX_W-1:0] scan_slot,
   output logic scan_slot_valid,
   output logic scan_use_reference_low,
   output logic [NUM_PINS-1:0] pin_digital_mode,
   output logic [NUM_PINS-1:0] port_read_enable,
   output logic [NUM_PINS-1:0] mux_to_analog_ground
);
   initial begin
      if (NUM_PINS < 1 || NUM_PINS > ASC_NUM_SLOTS) begin
         $error("asc_top: NUM_PINS out of range");
      end
   end

   // Reset release synchroniser
   logic rst_s1;
   logic rst_n;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n <= rst_s1;
      end
   end

   // Disable input crosses from another block
   logic dis_s1;
   logic dis_s2;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dis_s1 <= 1'b0;
         dis_s2 <= 1'b0;
      end else if (clk_en) begin
         dis_s1 <= converter_module_disable;
         dis_s2 <= dis_s1;
      end
   end

   logic [15:0] scan_lower;
   logic [15:0] scan_upper;
   logic [15:0] pin_digital_select_bit_lower;
   logic [15:0] pin_digital_select_bit_upper;
   logic [15:0] pcfg2_lower;

   logic wr_en;
   logic rd_en;
   logic addr_ok;
   assign wr_en = psel && penable && pwrite && clk_en;
   assign rd_en = psel && penable && !pwrite && clk_en;

   // Address decode
   function automatic logic known_addr(input logic [7:0] a);
      known_addr = (a == ASC_OFS_SCAN_LOWER) || (a == ASC_OFS_SCAN_UPPER) ||
                   (a == ASC_OFS_PIN_DIGITAL_SELECT_BIT_LOWER) || (a == ASC_OFS_PIN_DIGITAL_SELECT_BIT_UPPER) ||
                   (a == ASC_OFS_PCFG2_LOWER && HAS_SECOND) ||
                   (a == ASC_OFS_SCAN_STATUS);
   endfunction
   assign addr_ok = known_addr(paddr);

   // Zero-wait answer; unmapped gets an error
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_ok;

   // Scan-select registers, all 16 bits writable
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         scan_lower <= ASC_REG_RESET;
         scan_upper <= ASC_REG_RESET;
      end else if (wr_en) begin
         if (paddr == ASC_OFS_SCAN_LOWER) begin
            scan_lower <= pwdata[15:0];
         end
         if (paddr == ASC_OFS_SCAN_UPPER) begin
            scan_upper <= pwdata[15:0];
         end
      end
   end

   // Pin-config registers, all bits read/write; pcfg2_lower only with HAS_SECOND
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_digital_select_bit_lower <= ASC_REG_RESET;
         pin_digital_select_bit_upper <= ASC_REG_RESET;
         pcfg2_lower <= ASC_REG_RESET;
      end else if (wr_en) begin
         if (paddr == ASC_OFS_PIN_DIGITAL_SELECT_BIT_LOWER) begin
            pin_digital_select_bit_lower <= pwdata[15:0];
         end
         if (paddr == ASC_OFS_PIN_DIGITAL_SELECT_BIT_UPPER) begin
            pin_digital_select_bit_upper <= pwdata[15:0];
         end
         if (paddr == ASC_OFS_PCFG2_LOWER && HAS_SECOND) begin
            pcfg2_lower <= pwdata[15:0];
         end
      end
   end

   // Scan mask: upper register is slots 16-31
   logic [ASC_NUM_SLOTS-1:0] scan_mask;
   assign scan_mask = {scan_upper, scan_lower};

   asc_scan_seq #(
      .NUM_SLOTS(ASC_NUM_SLOTS)
   ) u_seq (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .scan_mask(scan_mask),
      .advance(scan_advance),
      .slot(scan_slot),
      .slot_valid(scan_slot_valid)
   );

   // Slots with no physical input convert the low reference
   assign scan_use_reference_low = scan_slot_valid &&
                                   (32'(scan_slot) >= NUM_PINS);

   logic [NUM_PINS-1:0] pin_digital;
   logic [NUM_PINS-1:0] pin_analog;
   asc_pin_mode #(
      .NUM_PINS(NUM_PINS)
   ) u_pin (
      .pcfg1({pin_digital_select_bit_upper, pin_digital_select_bit_lower}),
      .pcfg2(pcfg2_lower),
      .has_second(HAS_SECOND),
      .module_disable(dis_s2),
      .pin_digital(pin_digital),
      .pin_analog(pin_analog)
   );

   // Pin outputs registered; only present pins exist, so absent bits drive nothing
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_digital_mode <= '0;
         port_read_enable <= '0;
         mux_to_analog_ground <= '0;
      end else if (clk_en) begin
         pin_digital_mode <= pin_digital;
         port_read_enable <= ~pin_analog;
         mux_to_analog_ground <= pin_digital;
      end
   end

   // Read data, registered
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= '0;
      end else if (psel && !penable && !pwrite && clk_en) begin
         prdata <= '0;
         case (paddr)
            ASC_OFS_SCAN_LOWER: prdata <= {16'h0000, scan_lower};
            ASC_OFS_SCAN_UPPER: prdata <= {16'h0000, scan_upper};
            ASC_OFS_PIN_DIGITAL_SELECT_BIT_LOWER: prdata <= {16'h0000, pin_digital_select_bit_lower};
            ASC_OFS_PIN_DIGITAL_SELECT_BIT_UPPER: prdata <= {16'h0000, pin_digital_select_bit_upper};
            ASC_OFS_PCFG2_LOWER: prdata <= HAS_SECOND ? {16'h0000, pcfg2_lower} : 32'h0000_0000;
            ASC_OFS_SCAN_STATUS: begin
               prdata[ASC_STAT_SLOT_LSB +: ASC_IDX_W] <= scan_slot;
               prdata[ASC_STAT_VALID_BIT] <= scan_slot_valid;
            end
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   a_disable_digital: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (clk_en && dis_s2) |=> (&pin_digital_mode))
      else $error("pin left analog while disabled");
   a_pin_digital_select_bit_analog: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (clk_en && !dis_s2 && pin_digital_select_bit_lower[0] == 1'b0 && !(HAS_SECOND && pcfg2_lower[0]))
      |=> !port_read_enable[0])
      else $error("pin 0 not analog");
   a_pin_digital_select_bit_digital: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (clk_en && pin_digital_select_bit_lower[0]) |=> (mux_to_analog_ground[0] && port_read_enable[0]))
      else $error("pin 0 not digital");
   a_scan_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wr_en && paddr == ASC_OFS_SCAN_LOWER) |=> scan_mask[15:0] == $past(pwdata[15:0]))
      else $error("lower scan write lost");
   a_upper_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wr_en && paddr == ASC_OFS_SCAN_UPPER) |=> scan_mask[31:16] == $past(pwdata[15:0]))
      else $error("upper scan write lost");
   a_skip_empty: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (clk_en && scan_advance && scan_mask == 32'h0000_0000) |=> !scan_slot_valid)
      else $error("scan valid with empty mask");
   a_ref_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (scan_slot_valid && 32'(scan_slot) >= NUM_PINS) |-> scan_use_reference_low)
      else $error("absent slot not on reference");
   a_second_pin_digital_select_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (clk_en && HAS_SECOND && pcfg2_lower[1]) |=> pin_digital_mode[1])
      else $error("second config ignored");
endmodule
`default_nettype wire

// >>> asc_pkg.sv
// Package: register map, reset values and scan constants for the scan and pin config block
//
// Function
// - A scan-select bit of 1 puts its analog input in the scan, a 0 skips it.
// - Upper scan-select bits 0 to 15 stand for analog inputs 16 to 31.
// - Lower scan-select bits 0 to 15 stand for analog inputs 0 to 15.
// - Every upper scan bit is writable, and a scanned slot with no input converts the low reference.
// - Every lower scan bit is writable, and a scanned slot with no input converts the low reference.
// - A pin-config bit of 1 makes the pin digital, enables its port read and grounds the mux input.
// - A pin-config bit of 0 makes the pin analog, disables its port read and the converter samples it.
// - Every pin-config bit is read/write, the second lower register only when HAS_SECOND is set, but bits of absent inputs touch no pin.
// - Upper pin-config bits map to pins 16 to 31 and lower bits to pins 0 to 15.
// - The second converter has no upper pin-config register and selects only inputs 0 to 15.
// - With two converters both lower pin-config registers affect the shared pins 0 to 15.
// - While the converter is disabled, pin-config bits do nothing and all shared pins are digital.
// - All scan-select and pin-config bits reset to 0.
package asc_pkg;
   localparam logic [7:0] ASC_OFS_SCAN_LOWER = 8'h00;
   localparam logic [7:0] ASC_OFS_SCAN_UPPER = 8'h04;
   localparam logic [7:0] ASC_OFS_PIN_DIGITAL_SELECT_BIT_LOWER = 8'h08;
   localparam logic [7:0] ASC_OFS_PIN_DIGITAL_SELECT_BIT_UPPER = 8'h0C;
   localparam logic [7:0] ASC_OFS_PCFG2_LOWER = 8'h10;
   localparam logic [7:0] ASC_OFS_SCAN_STATUS = 8'h14;
   localparam logic [15:0] ASC_REG_RESET = 16'h0000;
   localparam int ASC_NUM_SLOTS = 32;
   localparam int ASC_HALF_SLOTS = 16;
   localparam int ASC_IDX_W = 5;
   // Status layout: current slot in 4:0, slot-valid in 8
   localparam int ASC_STAT_SLOT_LSB = 0;
   localparam int ASC_STAT_VALID_BIT = 8;
endpackage

// >>> asc_scan_seq.sv
// Scan sequencer stepping through selected inputs in ascending order
`timescale 1ns/1ps
`default_nettype none
module asc_scan_seq
   import asc_pkg::*;
#(
   parameter int NUM_SLOTS = ASC_NUM_SLOTS
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [NUM_SLOTS-1:0] scan_mask,
   input wire logic advance,
   output logic [ASC_IDX_W-1:0] slot,
   output logic slot_valid
);
   initial begin
      if (NUM_SLOTS < 2 || NUM_SLOTS > (1 << ASC_IDX_W)) begin
         $error("asc_scan_seq: NUM_SLOTS out of range");
      end
   end

   // Next selected slot above cur, else lowest selected
   function automatic logic [ASC_IDX_W-1:0] next_sel(input logic [NUM_SLOTS-1:0] m,
                                                      input logic [ASC_IDX_W-1:0] cur);
      logic [ASC_IDX_W-1:0] low;
      logic [ASC_IDX_W-1:0] up;
      logic found_low;
      logic found_up;
      low = '0;
      up = '0;
      found_low = 1'b0;
      found_up = 1'b0;
      for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
         if (m[i]) begin
            low = ASC_IDX_W'(i);
            found_low = 1'b1;
            if (ASC_IDX_W'(i) > cur) begin
               up = ASC_IDX_W'(i);
               found_up = 1'b1;
            end
         end
      end
      next_sel = found_up ? up : (found_low ? low : cur);
   endfunction

   logic any_sel;
   assign any_sel = |scan_mask;

   // Slot pointer, moved on each conversion request while any slot is selected
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         slot <= '0;
      end else if (clk_en && advance && any_sel) begin
         slot <= next_sel(scan_mask, slot);
      end
   end

   // Current slot is a selected one
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         slot_valid <= 1'b0;
      end else if (clk_en) begin
         slot_valid <= advance ? any_sel : (slot_valid & scan_mask[slot]);
      end
   end

   a_seq_ascend: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (clk_en && advance && scan_mask[slot] && (scan_mask >> (slot + 1)) != 0)
      |=> slot > $past(slot))
      else $error("scan did not step upward");
endmodule
`default_nettype wire

// >>> asc_pin_mode.sv
// Pin mode logic: analog or digital per shared pin
`timescale 1ns/1ps
`default_nettype none
module asc_pin_mode
   import asc_pkg::*;
#(
   parameter int NUM_PINS = ASC_NUM_SLOTS
) (
   input wire logic [ASC_NUM_SLOTS-1:0] pcfg1,
   input wire logic [ASC_HALF_SLOTS-1:0] pcfg2,
   input wire logic has_second,
   input wire logic module_disable,
   output logic [NUM_PINS-1:0] pin_digital,
   output logic [NUM_PINS-1:0] pin_analog
);
   initial begin
      if (NUM_PINS < 1 || NUM_PINS > ASC_NUM_SLOTS) begin
         $error("asc_pin_mode: NUM_PINS out of range");
      end
   end

   // Digital when disabled or any config bit set
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         pin_digital[i] = module_disable | pcfg1[i];
         if (i < ASC_HALF_SLOTS) begin
            pin_digital[i] = pin_digital[i] | (has_second & pcfg2[i[3:0]]);
         end
         pin_analog[i] = ~pin_digital[i];
      end
   end
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the scan select and pin config block
`timescale 1ns/1ps
`default_nettype none
module tb
   import asc_pkg::*;
;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic clk_en = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic converter_module_disable = 1'b0;
   logic scan_advance = 1'b0;
   logic pin_chk = 1'b0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [ASC_IDX_W-1:0] scan_slot;
   logic scan_slot_valid;
   logic scan_use_reference_low;
   logic [23:0] pin_digital_mode;
   logic [23:0] port_read_enable;
   logic [23:0] mux_to_analog_ground;
   int err_count = 0;
   int n_compared = 0;
   int cyc = 0;
   logic [31:0] exp_q[$];
   logic [31:0] got;
   logic [31:0] want;
   logic [31:0] seed = 32'h0000_c087;
   logic [15:0] regv[5] = '{default: 16'h0000};
   logic [7:0] ofs[5] = '{ASC_OFS_SCAN_LOWER, ASC_OFS_SCAN_UPPER, ASC_OFS_PIN_DIGITAL_SELECT_BIT_LOWER,
      ASC_OFS_PIN_DIGITAL_SELECT_BIT_UPPER, ASC_OFS_PCFG2_LOWER};
   int slots[5] = '{3, 17, 28, 3, 17};

   asc_top #(.NUM_PINS(24), .HAS_SECOND(1'b1)) DUT (
      .ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .converter_module_disable(converter_module_disable),
      .scan_advance(scan_advance), .scan_slot(scan_slot), .scan_slot_valid(scan_slot_valid),
      .scan_use_reference_low(scan_use_reference_low), .pin_digital_mode(pin_digital_mode),
      .port_read_enable(port_read_enable), .mux_to_analog_ground(mux_to_analog_ground)
   );

   // Clock source
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Expected pin snapshot: low reference flag, mismatch flags, pin modes
   function automatic logic [31:0] pexp(input logic dis, input int slot);
      logic [23:0] p;
      p = dis ? 24'hFF_FFFF : ({regv[3][7:0], regv[2]} | {8'h00, regv[4]});
      return {slot >= 24, 7'h00, p};
   endfunction

   task automatic close_out();
      if (err_count == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // One APB transfer, request held until pready is seen
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0000_0000);
   endtask

   task automatic pin_note(input logic [31:0] e);
      exp_q.push_back(e);
      pin_chk <= 1'b1;
      @(posedge ref_clk);
      pin_chk <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic step();
      scan_advance <= 1'b1;
      @(posedge ref_clk);
      scan_advance <= 1'b0;
      @(posedge ref_clk);
   endtask

   // Watcher: compare each result with the oldest note; also cut hangs short
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 8000) begin
         err_count++;
         close_out();
      end
      if ((psel && penable && pready && !pwrite) || pin_chk) begin
         if (pin_chk) begin
            got = {scan_use_reference_low, |(port_read_enable ^ pin_digital_mode),
               |(mux_to_analog_ground ^ pin_digital_mode), 5'h00, pin_digital_mode};
         end else begin
            got = {pslverr, prdata[30:0]};
         end
         want = exp_q.pop_front();
         n_compared++;
         if (got !== want) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, want);
         end
      end
   end

   // Main sequence
   initial begin
      repeat (20) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge ref_clk);
      for (int i = 0; i < 5; i++) rd(ofs[i], 32'h0000_0000);
      rd(ASC_OFS_SCAN_STATUS, 32'h0000_0000);
      pin_note(pexp(1'b0, 0));
      // Random and all-ones patterns; upper half of write data must be dropped
      for (int k = 0; k < 3; k++) begin
         for (int i = 0; i < 5; i++) begin
            seed = lfsr(seed);
            regv[i] = (k == 1) ? 16'hFFFF : seed[15:0];
            wr(ofs[i], {seed[31:16], regv[i]});
         end
         for (int i = 0; i < 5; i++) rd(ofs[i], {16'h0000, regv[i]});
         pin_note(pexp(1'b0, 0));
      end
      wr(ASC_OFS_SCAN_STATUS, 32'h0000_011F);
      rd(ASC_OFS_SCAN_STATUS, 32'h0000_0000);
      rd(8'h18, 32'h8000_0000);
      wr(8'h18, 32'h0000_5A5A);
      rd(ofs[2], {16'h0000, regv[2]});
      // Write with the clock enable low must leave the register alone
      clk_en <= 1'b0;
      wr(ofs[2], {16'h0000, ~regv[2]});
      clk_en <= 1'b1;
      rd(ofs[2], {16'h0000, regv[2]});
      converter_module_disable <= 1'b1;
      repeat (5) @(posedge ref_clk);
      pin_note(pexp(1'b1, 0));
      converter_module_disable <= 1'b0;
      repeat (5) @(posedge ref_clk);
      pin_note(pexp(1'b0, 0));
      // Scan inputs 3, 17 and 28; slot 28 has no pin behind it
      regv[0] = 16'h0008;
      regv[1] = 16'h1002;
      wr(ofs[0], {16'h0000, regv[0]});
      wr(ofs[1], {16'h0000, regv[1]});
      for (int i = 0; i < 5; i++) begin
         step();
         rd(ASC_OFS_SCAN_STATUS, 32'h0000_0100 | slots[i]);
         pin_note(pexp(1'b0, slots[i]));
      end
      wr(ofs[0], 32'h0000_0000);
      wr(ofs[1], 32'h0000_0000);
      step();
      rd(ASC_OFS_SCAN_STATUS, 32'h0000_0011);
      // Second reset in mid-run
      rst_b <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge ref_clk);
      regv = '{default: 16'h0000};
      rd(ofs[3], 32'h0000_0000);
      pin_note(pexp(1'b0, 0));
      close_out();
   end
endmodule
`default_nettype wire
